//--- logic/nbfrm_pkg.sv
package nbfrm_pkg;
  localparam logic [9:0] ETH_HDR_LEN  = 10'd14;
  localparam logic [9:0] OFF_SRC      = 10'd6;
  localparam logic [9:0] OFF_TYPE     = 10'd12;
  localparam logic [9:0] OFF_SUBTYPE  = 10'd0;
  localparam logic [9:0] OFF_MSG_ID   = 10'd2;
  localparam logic [9:0] OFF_REQ_CODE = 10'd18;
  localparam logic [9:0] OFF_RPL_CODE = 10'd19;
  localparam logic [9:0] OFF_LENGTH   = 10'd20;
  localparam logic [9:0] OFF_BODY     = 10'd22;
  localparam logic [9:0] OFF_BUF_CNT  = 10'd24;
  localparam logic [9:0] OFF_BUF_LEN  = 10'd26;
  localparam logic [9:0] OFF_PARTY    = 10'd28;
  localparam logic [9:0] OFF_SESSION  = 10'd34;
  localparam logic [9:0] OFF_TIMEOUT  = 10'd46;
  localparam logic [9:0] SC_REQ_LEN   = 10'd106;
  localparam logic [9:0] SC_RPL_LEN   = 10'd26;
  localparam logic [7:0] CODE_MEM_WR  = 8'h00;
  localparam logic [7:0] CODE_MEM_RD  = 8'h01;
  localparam logic [7:0] CODE_RUN     = 8'h02;
  localparam logic [7:0] CODE_SETUP   = 8'h03;
  localparam logic [7:0] CODE_SEARCH  = 8'h04;
  localparam logic [7:0] CODE_CHOICE  = 8'h05;
  localparam logic [15:0] PROTO_VER   = 16'h0001;
  localparam logic [15:0] BUF_LEN     = 16'h01fc;
  localparam logic [15:0] BUF_COUNT   = 16'h0001;

  typedef enum logic [0:0] {
    NBFRM_IDLE = 1'b0,
    NBFRM_SEND = 1'b1
  } nbfrm_tx_st_t;

  // Byte i of a little-endian identifier, byte 0 in the low bits
  function automatic logic [7:0] nbfrm_le_byte(input logic [127:0] v,
                                               input logic [3:0] i);
    logic [127:0] s;
    s = v >> {i, 3'b000};
    return s[7:0];
  endfunction

  // Byte i of a station address; byte 0 sits in the top bits
  function automatic logic [7:0] nbfrm_mac_byte(input logic [47:0] a,
                                                input logic [2:0] i);
    logic [47:0] s;
    s = a >> {3'(3'd5 - i), 3'b000};
    return s[7:0];
  endfunction
endpackage

//--- logic/nbfrm_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module nbfrm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- logic/nbfrm_framer.sv
`timescale 1ns/1ns
`default_nettype none
module nbfrm_framer #(
  // Frame type value is arbitrary here; set it for the real network
  parameter logic [15:0] ETH_TYPE   = 16'h0bad,
  parameter int          FIFO_DEPTH = 32
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [47:0]  own_addr,
  input  wire logic [95:0]  session_tag,
  input  wire logic [15:0]  reply_timeout,
  input  wire logic         tx_start,
  input  wire logic         tx_kind,
  input  wire logic [7:0]   cmd_code,
  input  wire logic [31:0]  cmd_serial,
  input  wire logic [8:0]   cmd_len,
  input  wire logic [7:0]   cmd_data,
  input  wire logic         cmd_data_valid,
  output logic              cmd_data_ready,
  output logic              tx_busy,
  output logic              tx_bit,
  output logic              tx_bit_valid,
  output logic              tx_bit_last,
  input  wire logic         rx_bit,
  input  wire logic         rx_bit_valid,
  input  wire logic         rx_end,
  output logic              rx_msg_valid,
  output logic              rx_discard,
  output logic [7:0]        rx_code,
  output logic [7:0]        rx_reply_code,
  output logic [127:0]      rx_msg_id,
  output logic [47:0]       rx_src_addr,
  output logic [47:0]       rx_party_addr,
  output logic [15:0]       rx_length,
  output logic              rx_is_reply,
  output logic              rx_malformed,
  output logic              rx_bad_field,
  output logic              rx_session_ok,
  output logic              client_known
);
  localparam logic [9:0] HDR_END = nbfrm_pkg::ETH_HDR_LEN + nbfrm_pkg::OFF_BODY;

  nbfrm_pkg::nbfrm_tx_st_t st_q;
  logic         kind_q;
  logic [9:0]   pos_q;
  logic [9:0]   last_q;
  logic [2:0]   bitc_q;
  logic [7:0]   sr_q;
  logic         have_q;
  logic [7:0]   ccode_q;
  logic [31:0]  cser_q;
  logic [15:0]  clen_q;
  logic [7:0]   hdr_byte;
  logic [9:0]   off;
  logic         need_fifo;
  logic [7:0]   fifo_d;
  logic         fifo_v;
  logic [127:0] tx_id;
  logic [7:0]   tx_code;
  logic [15:0]  tx_len;
  logic [47:0]  tx_dst;

  // Latched from the last search/choice request that is not malformed, even if it has a bad field
  logic [127:0] lat_id_q;
  logic [7:0]   lat_code_q;
  logic [47:0]  lat_client_q;
  logic [15:0]  lat_ver_q;
  logic [15:0]  lat_bcnt_q;
  logic [15:0]  lat_blen_q;

  nbfrm_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_data   (cmd_data),
    .in_valid  (cmd_data_valid),
    .in_ready  (cmd_data_ready),
    .out_data  (fifo_d),
    .out_valid (fifo_v),
    .out_ready (need_fifo && !have_q && st_q == nbfrm_pkg::NBFRM_SEND)
  );

  assign tx_busy     = st_q != nbfrm_pkg::NBFRM_IDLE;
  assign need_fifo   = kind_q && pos_q >= HDR_END;
  assign tx_bit      = sr_q[0];
  assign tx_bit_valid = have_q;
  assign tx_bit_last = have_q && bitc_q == 3'd7 && pos_q == last_q;
  assign off         = pos_q - nbfrm_pkg::ETH_HDR_LEN;

  // Replies echo the request's identity; commands carry the session tag
  assign tx_id   = kind_q ? {cser_q, session_tag} : lat_id_q;
  assign tx_code = kind_q ? ccode_q : lat_code_q;
  assign tx_len  = kind_q ? clen_q : 16'(nbfrm_pkg::SC_RPL_LEN);
  assign tx_dst  = lat_client_q;

  always_comb begin
    hdr_byte = 8'h00;
    if (pos_q < nbfrm_pkg::OFF_SRC) begin
      hdr_byte = nbfrm_pkg::nbfrm_mac_byte(tx_dst, pos_q[2:0]);
    end else if (pos_q < nbfrm_pkg::OFF_TYPE) begin
      hdr_byte = nbfrm_pkg::nbfrm_mac_byte(own_addr, 3'(pos_q - nbfrm_pkg::OFF_SRC));
    end else if (pos_q == nbfrm_pkg::OFF_TYPE) begin
      hdr_byte = ETH_TYPE[15:8];
    end else if (pos_q < nbfrm_pkg::ETH_HDR_LEN) begin
      hdr_byte = ETH_TYPE[7:0];
    end else if (off < nbfrm_pkg::OFF_MSG_ID) begin
      hdr_byte = 8'h00;
    end else if (off < nbfrm_pkg::OFF_REQ_CODE) begin
      hdr_byte = nbfrm_pkg::nbfrm_le_byte(tx_id, 4'(off - nbfrm_pkg::OFF_MSG_ID));
    end else if (off == nbfrm_pkg::OFF_REQ_CODE) begin
      hdr_byte = tx_code;
    end else if (off == nbfrm_pkg::OFF_RPL_CODE) begin
      hdr_byte = 8'h00;
    end else if (off == nbfrm_pkg::OFF_LENGTH) begin
      hdr_byte = tx_len[7:0];
    end else if (off == nbfrm_pkg::OFF_LENGTH + 10'd1) begin
      hdr_byte = tx_len[15:8];
    end else if (off < nbfrm_pkg::OFF_BUF_CNT) begin
      hdr_byte = off[0] ? lat_ver_q[15:8] : lat_ver_q[7:0];
    end else if (off < nbfrm_pkg::OFF_BUF_LEN) begin
      hdr_byte = off[0] ? lat_bcnt_q[15:8] : lat_bcnt_q[7:0];
    end else if (off < nbfrm_pkg::OFF_PARTY) begin
      hdr_byte = off[0] ? lat_blen_q[15:8] : lat_blen_q[7:0];
    end else if (off < nbfrm_pkg::OFF_SESSION) begin
      hdr_byte = nbfrm_pkg::nbfrm_mac_byte(own_addr,
                   3'(off - nbfrm_pkg::OFF_PARTY));
    end else if (off < nbfrm_pkg::OFF_TIMEOUT) begin
      hdr_byte = nbfrm_pkg::nbfrm_le_byte({32'h0, session_tag},
                   4'(off - nbfrm_pkg::OFF_SESSION));
    end else begin
      hdr_byte = off[0] ? reply_timeout[15:8] : reply_timeout[7:0];
    end
  end

  // Transmit sequencer: one idle cycle between bytes while the next loads, more while the FIFO is empty
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q    <= nbfrm_pkg::NBFRM_IDLE;
      kind_q  <= 1'b0;
      pos_q   <= '0;
      last_q  <= '0;
      bitc_q  <= '0;
      sr_q    <= '0;
      have_q  <= 1'b0;
      ccode_q <= '0;
      cser_q  <= '0;
      clen_q  <= '0;
    end else begin
      unique case (st_q)
        nbfrm_pkg::NBFRM_IDLE: begin
          have_q <= 1'b0;
          if (tx_start) begin
            st_q    <= nbfrm_pkg::NBFRM_SEND;
            kind_q  <= tx_kind;
            pos_q   <= '0;
            bitc_q  <= '0;
            ccode_q <= cmd_code;
            cser_q  <= cmd_serial;
            clen_q  <= 16'(cmd_len);
            last_q  <= HDR_END - 10'd1 + (tx_kind ? 10'(cmd_len)
                                                  : nbfrm_pkg::SC_RPL_LEN);
          end
        end
        nbfrm_pkg::NBFRM_SEND: begin
          if (!have_q) begin
            if (!need_fifo) begin
              sr_q   <= hdr_byte;
              have_q <= 1'b1;
            end else if (fifo_v) begin
              sr_q   <= fifo_d;
              have_q <= 1'b1;
            end
          end else begin
            sr_q   <= {1'b0, sr_q[7:1]};
            bitc_q <= bitc_q + 3'd1;
            if (bitc_q == 3'd7) begin
              have_q <= 1'b0;
              pos_q  <= pos_q + 10'd1;
              if (pos_q == last_q) begin
                st_q <= nbfrm_pkg::NBFRM_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // Receive side
  logic [2:0]   rbit_q;
  logic [6:0]   rsr_q;
  logic [9:0]   rpos_q;
  logic [9:0]   roff;
  logic [7:0]   rb;
  logic         rb_v;
  logic [47:0]  src_q;
  logic [15:0]  type_q;
  logic         sub_nz_q;
  logic [127:0] id_q;
  logic [7:0]   code_q;
  logic [7:0]   rc_q;
  logic [15:0]  len_q;
  logic [15:0]  ver_q;
  logic [15:0]  bcnt_q;
  logic [15:0]  blen_q;
  logic [47:0]  party_q;
  logic [15:0]  after_q;
  logic         keep;
  logic         is_sc;
  logic         malf;

  assign rb   = {rx_bit, rsr_q};
  assign rb_v = rx_bit_valid && rbit_q == 3'd7;
  assign roff = rpos_q - nbfrm_pkg::ETH_HDR_LEN;
  assign keep = type_q == ETH_TYPE && !sub_nz_q && rpos_q >= HDR_END;
  // Requests and replies share codes; only search/choice come in as requests
  assign is_sc = code_q == nbfrm_pkg::CODE_SEARCH
              || code_q == nbfrm_pkg::CODE_CHOICE;
  assign malf  = len_q > after_q;

  always_ff @(posedge mclk) begin
    if (sys_rst || rx_end) begin
      rbit_q <= '0;
      rsr_q  <= '0;
    end else if (rx_bit_valid) begin
      rbit_q <= rbit_q + 3'd1;
      rsr_q  <= {rx_bit, rsr_q[6:1]};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || rx_end) begin
      rpos_q   <= '0;
      sub_nz_q <= 1'b0;
      after_q  <= '0;
      type_q   <= '0;
    end else if (rb_v) begin
      if (rpos_q != 10'h3ff) begin
        rpos_q <= rpos_q + 10'd1;
      end
      if (rpos_q >= nbfrm_pkg::OFF_SRC && rpos_q < nbfrm_pkg::OFF_TYPE) begin
        src_q <= {src_q[39:0], rb};
      end else if (rpos_q < nbfrm_pkg::ETH_HDR_LEN && rpos_q >= nbfrm_pkg::OFF_TYPE) begin
        type_q <= {type_q[7:0], rb};
      end else if (rpos_q >= nbfrm_pkg::ETH_HDR_LEN) begin
        if (roff < nbfrm_pkg::OFF_MSG_ID) begin
          sub_nz_q <= sub_nz_q || rb != 8'h00;
        end else if (roff < nbfrm_pkg::OFF_REQ_CODE) begin
          id_q <= {rb, id_q[127:8]};
        end else if (roff == nbfrm_pkg::OFF_REQ_CODE) begin
          code_q <= rb;
        end else if (roff == nbfrm_pkg::OFF_RPL_CODE) begin
          rc_q <= rb;
        end else if (roff < nbfrm_pkg::OFF_BODY) begin
          len_q <= {rb, len_q[15:8]};
        end else begin
          if (after_q != 16'hffff) begin
            after_q <= after_q + 16'd1;
          end
          if (roff < nbfrm_pkg::OFF_BUF_CNT) begin
            ver_q <= {rb, ver_q[15:8]};
          end else if (roff < nbfrm_pkg::OFF_BUF_LEN) begin
            bcnt_q <= {rb, bcnt_q[15:8]};
          end else if (roff < nbfrm_pkg::OFF_PARTY) begin
            blen_q <= {rb, blen_q[15:8]};
          end else if (roff < nbfrm_pkg::OFF_SESSION) begin
            party_q <= {party_q[39:0], rb};
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_msg_valid  <= 1'b0;
      rx_discard    <= 1'b0;
      rx_code       <= '0;
      rx_reply_code <= '0;
      rx_msg_id     <= '0;
      rx_src_addr   <= '0;
      rx_party_addr <= '0;
      rx_length     <= '0;
      rx_is_reply   <= 1'b0;
      rx_malformed  <= 1'b0;
      rx_bad_field  <= 1'b0;
      rx_session_ok <= 1'b0;
    end else begin
      rx_msg_valid <= rx_end && keep;
      rx_discard   <= rx_end && !keep;
      if (rx_end && keep) begin
        rx_code       <= code_q;
        rx_reply_code <= rc_q;
        rx_msg_id     <= id_q;
        rx_src_addr   <= src_q;
        rx_party_addr <= party_q;
        rx_length     <= len_q;
        rx_is_reply   <= !is_sc;
        rx_malformed  <= malf;
        rx_bad_field  <= is_sc && (rc_q != 8'h00
                      || len_q != 16'(nbfrm_pkg::SC_REQ_LEN)
                      || ver_q != nbfrm_pkg::PROTO_VER);
        rx_session_ok <= id_q[95:0] == session_tag;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      client_known <= 1'b0;
      lat_id_q     <= '0;
      lat_code_q   <= nbfrm_pkg::CODE_SEARCH;
      lat_client_q <= '0;
      lat_ver_q    <= nbfrm_pkg::PROTO_VER;
      lat_bcnt_q   <= nbfrm_pkg::BUF_COUNT;
      lat_blen_q   <= nbfrm_pkg::BUF_LEN;
    end else if (rx_end && keep && is_sc && !malf) begin
      client_known <= 1'b1;
      lat_id_q     <= id_q;
      lat_code_q   <= code_q;
      lat_client_q <= src_q;
      lat_ver_q    <= ver_q;
      lat_bcnt_q   <= bcnt_q;
      lat_blen_q   <= blen_q;
    end
  end
endmodule
`default_nettype wire

//--- testbench/nbfrm_client_model.sv
`timescale 1ns/1ns
`default_nettype none
module nbfrm_client_model #(
  parameter logic [47:0] CLIENT_ADDR = 48'h0,
  parameter logic [47:0] SERVER_ADDR = 48'h0
) (
  input  wire logic mclk,
  output logic      rx_bit,
  output logic      rx_bit_valid,
  output logic      rx_end,
  input  wire logic tx_bit,
  input  wire logic tx_bit_valid,
  input  wire logic tx_bit_last
);
  logic [7:0] seen_q[$];
  logic [7:0] out_q[$];
  logic [7:0] shift_q;
  logic       data_q;
  logic       idle_q;
  int         nbit_q;
  int         frames_q;

  // Idle line toggles so a stale bit can never pass for data
  assign rx_bit = rx_bit_valid ? data_q : idle_q;

  initial begin
    data_q = 1'b0;
    idle_q = 1'b0;
    rx_bit_valid = 1'b0;
    rx_end = 1'b0;
    nbit_q = 0;
    frames_q = 0;
  end

  always @(posedge mclk) begin
    idle_q <= ~idle_q;
    if (tx_bit_valid) begin
      shift_q <= {tx_bit, shift_q[7:1]};
      nbit_q  <= (nbit_q == 7) ? 0 : nbit_q + 1;
      if (nbit_q == 7) begin
        seen_q.push_back({tx_bit, shift_q[7:1]});
      end
      if (tx_bit_last) begin
        frames_q <= frames_q + 1;
      end
    end
  end

  task automatic put(input logic [7:0] v);
    out_q.push_back(v);
  endtask

  task automatic put16(input logic [15:0] v);
    put(v[7:0]);
    put(v[15:8]);
  endtask

  task automatic send_msg(input logic [7:0] code, input logic [127:0] id,
                          input logic [7:0] rcode, input logic [15:0] len,
                          input int nbody, input logic [15:0] sub,
                          input logic [15:0] etype);
    logic [47:0] dst;
    dst = (code == 8'h04) ? 48'hffff_ffff_ffff : SERVER_ADDR;
    out_q.delete();
    for (int i = 5; i >= 0; i--) put(dst[8*i +: 8]);
    for (int i = 5; i >= 0; i--) put(CLIENT_ADDR[8*i +: 8]);
    put(etype[15:8]);
    put(etype[7:0]);
    put16(sub);
    for (int i = 0; i < 16; i++) put(id[8*i +: 8]);
    put(code);
    put(rcode);
    put16(len);
    put16(16'h0001);
    put16(16'h0001);
    put16(16'h01fc);
    for (int i = 5; i >= 0; i--) put(CLIENT_ADDR[8*i +: 8]);
    for (int i = 0; i < 12; i++) put(8'h5a);
    put16(16'h0bb8);
    for (int i = 26; i < nbody; i++) put(8'h00);
    foreach (out_q[j]) begin
      for (int k = 0; k < 8; k++) begin
        @(posedge mclk);
        data_q <= out_q[j][k];
        rx_bit_valid <= 1'b1;
      end
    end
    @(posedge mclk);
    rx_bit_valid <= 1'b0;
    @(posedge mclk);
    rx_end <= 1'b1;
    @(posedge mclk);
    rx_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/nbfrm_framer_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module nbfrm_framer_assertions (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [95:0]  session_tag,
  input  wire logic         tx_start,
  input  wire logic         tx_busy,
  input  wire logic         tx_bit_valid,
  input  wire logic         tx_bit_last,
  input  wire logic         rx_end,
  input  wire logic         rx_msg_valid,
  input  wire logic         rx_discard,
  input  wire logic [7:0]   rx_code,
  input  wire logic [7:0]   rx_reply_code,
  input  wire logic [127:0] rx_msg_id,
  input  wire logic         rx_is_reply,
  input  wire logic         rx_malformed,
  input  wire logic         rx_bad_field,
  input  wire logic         rx_session_ok,
  input  wire logic         client_known
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence launch_s;
    tx_start && !tx_busy;
  endsequence
  sequence first_bits_s;
    tx_busy && !tx_bit_valid ##1 tx_bit_valid;
  endsequence
  sequence byte_s;
    tx_bit_valid [*8] ##1 !tx_bit_valid;
  endsequence

  start_load_a: assert property (launch_s |=> first_bits_s)
    else $error("first bit not two cycles after launch");
  byte_bits_a: assert property ($rose(tx_bit_valid) |-> byte_s)
    else $error("byte not eight bits then a gap");
  idle_quiet_a: assert property (!tx_busy |-> !tx_bit_valid)
    else $error("bit valid while idle");
  last_done_a: assert property (tx_bit_last |-> tx_bit_valid ##1 !tx_busy)
    else $error("busy after final bit");
  rx_answer_a: assert property (rx_end |=> rx_msg_valid != rx_discard)
    else $error("no single verdict after frame end");
  rx_cause_a: assert property (rx_msg_valid || rx_discard |-> $past(rx_end))
    else $error("verdict without frame end");
  hold_fields_a: assert property ($changed(rx_msg_id) || $changed(rx_code)
    |-> rx_msg_valid)
    else $error("received fields moved without a message");
  reply_kind_a: assert property (rx_msg_valid
    |-> rx_is_reply == !(rx_code inside {8'h04, 8'h05}))
    else $error("reply flag does not follow code");
  session_match_a: assert property (rx_msg_valid
    |-> rx_session_ok == (rx_msg_id[95:0] == session_tag))
    else $error("session flag wrong");
  no_field_err_a: assert property (rx_msg_valid && rx_is_reply |-> !rx_bad_field)
    else $error("field error on a reply");
  rcode_flag_a: assert property (rx_msg_valid && !rx_is_reply
    && rx_reply_code != 8'h00 |-> rx_bad_field)
    else $error("nonzero reply code in request not flagged");
  known_client_a: assert property (rx_msg_valid && !rx_is_reply
    && !rx_malformed |-> client_known)
    else $error("good request did not latch client");
endmodule
bind nbfrm_framer nbfrm_framer_assertions u_chk (.mclk, .sys_rst, .session_tag, .tx_start,
  .tx_busy, .tx_bit_valid, .tx_bit_last, .rx_end, .rx_msg_valid, .rx_discard, .rx_code,
  .rx_reply_code, .rx_msg_id, .rx_is_reply, .rx_malformed, .rx_bad_field, .rx_session_ok,
  .client_known);
`default_nettype wire

//--- testbench/nbfrm_framer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module nbfrm_framer_tb;
  localparam logic [15:0] ETYPE = 16'h0bad;
  localparam logic [47:0] SRV   = 48'h02_11_22_33_44_55;
  localparam logic [47:0] CLI   = 48'h02_aa_bb_cc_dd_ee;
  localparam logic [95:0] SESS  = 96'h0123_4567_89ab_cdef_0f1e_2d3c;
  localparam logic [15:0] TMO   = 16'h0bb8;
  localparam logic [31:0] SER   = 32'h0000_0007;
  logic         mclk, sys_rst, tx_start, tx_kind, cmd_data_valid, cmd_data_ready, tx_busy;
  logic         tx_bit, tx_bit_valid, tx_bit_last, rx_bit, rx_bit_valid, rx_end;
  logic         rx_msg_valid, rx_discard, rx_is_reply, rx_malformed, rx_bad_field;
  logic         rx_session_ok, client_known;
  logic [7:0]   cmd_code, cmd_data, rx_code, rx_reply_code;
  logic [31:0]  cmd_serial;
  logic [8:0]   cmd_len;
  logic [127:0] rx_msg_id;
  logic [47:0]  rx_src_addr, rx_party_addr;
  logic [15:0]  rx_length;
  int           errors, comparisons;

  nbfrm_framer #(.ETH_TYPE(ETYPE), .FIFO_DEPTH(32)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .own_addr(SRV), .session_tag(SESS),
    .reply_timeout(TMO), .tx_start(tx_start), .tx_kind(tx_kind), .cmd_code(cmd_code),
    .cmd_serial(cmd_serial), .cmd_len(cmd_len), .cmd_data(cmd_data),
    .cmd_data_valid(cmd_data_valid), .cmd_data_ready(cmd_data_ready), .tx_busy(tx_busy),
    .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_bit_last(tx_bit_last),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_end(rx_end),
    .rx_msg_valid(rx_msg_valid), .rx_discard(rx_discard), .rx_code(rx_code),
    .rx_reply_code(rx_reply_code), .rx_msg_id(rx_msg_id), .rx_src_addr(rx_src_addr),
    .rx_party_addr(rx_party_addr), .rx_length(rx_length), .rx_is_reply(rx_is_reply),
    .rx_malformed(rx_malformed), .rx_bad_field(rx_bad_field),
    .rx_session_ok(rx_session_ok), .client_known(client_known));

  nbfrm_client_model #(.CLIENT_ADDR(CLI), .SERVER_ADDR(SRV)) cli (
    .mclk(mclk), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_end(rx_end),
    .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_bit_last(tx_bit_last));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Byte at offset at lands in the low bits unless big-endian is asked for
  function automatic logic [127:0] got(input int at, input int n, input bit be);
    logic [127:0] v;
    v = '0;
    for (int i = 0; i < n; i++) begin
      if (be) v = {v[119:0], cli.seen_q[at+i]};
      else v[8*i +: 8] = cli.seen_q[at+i];
    end
    return v;
  endfunction

  // Start is held over the busy edge too, so a second request is offered and refused
  task automatic launch(input logic kind, input logic [7:0] code, input logic [8:0] len);
    int f0;
    f0 = cli.frames_q;
    cli.seen_q.delete();
    @(posedge mclk);
    tx_start <= 1'b1;
    tx_kind <= kind;
    cmd_code <= code;
    cmd_len <= len;
    repeat (2) @(posedge mclk);
    tx_start <= 1'b0;
    for (int n = 0; n < 3000 && cli.frames_q == f0; n++) @(posedge mclk);
    repeat (30) @(posedge mclk);
    check(128'(cli.frames_q - f0), 128'h1);
  endtask

  task automatic chk_hdr(input logic [7:0] code, input logic [127:0] id, input logic [15:0] len);
    check(128'(cli.seen_q.size()), 128'(len) + 128'h24);
    check(got(0, 6, 1), CLI);
    check(got(6, 6, 1), SRV);
    check(got(12, 2, 1), ETYPE);
    check(got(14, 2, 0), 16'h0000);
    check(got(16, 16, 0), id);
    check(got(32, 1, 0), code);
    check(got(33, 1, 0), 8'h00);
    check(got(34, 2, 0), len);
  endtask

  task automatic t_reset;
    check({tx_busy, tx_bit_valid, rx_msg_valid, rx_discard, client_known, rx_code}, '0);
  endtask

  task automatic t_exchange(input logic [7:0] code, input logic [127:0] id);
    cli.send_msg(code, id, 8'h00, 16'h006a, 106, 16'h0000, ETYPE);
    #1;
    check({rx_msg_valid, rx_code, rx_length}, {1'b1, code, 16'h006a});
    check(rx_msg_id, id);
    check({rx_src_addr, rx_party_addr}, {CLI, CLI});
    check({rx_is_reply, rx_malformed, rx_bad_field, client_known}, 4'b0001);
    launch(1'b0, 8'h00, 9'h000);
    chk_hdr(code, id, 16'h001a);
    check(got(36, 4, 0), 32'h0001_0001);
    check(got(40, 2, 0), 16'h01fc);
    check(got(42, 6, 1), SRV);
    check(got(48, 12, 0), SESS);
    check(got(60, 2, 0), TMO);
  endtask

  task automatic t_faults;
    localparam logic [15:0] FAULT_EXP = 16'b1000_1000_0111_0101;
    for (int i = 0; i < 4; i++) begin
      cli.send_msg(8'h05, 128'h1234, 8'(i == 3), (i == 2) ? 16'h0078 : 16'h006a, 106,
                   16'(i == 1), (i == 0) ? ETYPE ^ 16'h0001 : ETYPE);
      #1;
      check({rx_discard, rx_msg_valid, rx_malformed, rx_bad_field},
            FAULT_EXP[15-4*i -: 4]);
      check(rx_reply_code, 8'(i == 3));
    end
  endtask

  task automatic t_cmd_reply;
    for (int i = 0; i < 2; i++) begin
      cli.send_msg(8'h01, {SER, (i == 1) ? SESS ^ 96'h1 : SESS}, 8'h00, 16'h001a, 26,
                   16'h0000, ETYPE);
      #1;
      check({rx_msg_valid, rx_is_reply, rx_session_ok}, {2'b11, i == 0});
    end
  endtask

  task automatic push(input logic [7:0] v);
    @(posedge mclk);
    cmd_data <= v;
    cmd_data_valid <= 1'b1;
    do @(negedge mclk); while (cmd_data_ready !== 1'b1);
    @(posedge mclk);
    cmd_data_valid <= 1'b0;
  endtask

  // A full FIFO must refuse before the long command drains it
  task automatic t_commands;
    int n;
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 32 : 1;
      for (int i = 0; i < n; i++) push(8'h40 + 8'(i + c));
      @(negedge mclk);
      check(cmd_data_ready, c != 0);
      launch(1'b1, 8'(c), 9'(n));
      chk_hdr(8'(c), {SER, SESS}, 16'(n));
      for (int i = 0; i < n; i++) check(cli.seen_q[36+i], 8'h40 + 8'(i + c));
    end
  endtask

  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    complete_run;
  end

  initial begin
    errors = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    tx_start = 1'b0;
    tx_kind = 1'b0;
    cmd_code = 8'h00;
    cmd_serial = SER;
    cmd_len = 9'h000;
    cmd_data = 8'h00;
    cmd_data_valid = 1'b0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    t_reset;
    t_exchange(8'h04, 128'h0f0e0d0c_0b0a0908_07060504_03020100);
    t_exchange(8'h05, 128'hf0e1d2c3_b4a59687_78695a4b_3c2d1e0f);
    t_faults;
    t_cmd_reply;
    t_commands;
    complete_run;
  end
endmodule
`default_nettype wire
